// >>> hdl/bsp_top.sv
// clock source selection, pin control and multichannel enables of the serial port
//
// Function
// - source ext pcr bit7, clock mode rg2 bit13
// - two bits pick reserved, cpu, rx pin, tx pin
// - pin chosen as source stops driving
// - rx pin source drives generator on tx only
// - pin control layout, resets to zero
// - independent tx/rx enables, 128 channels
// - enhanced mode bit 9 in each control
// - enhanced off: partitions a,b, 32 channels
// - enhanced on: partitions a..h, 128 channels
// - receive enable bit per channel, reset zero
// - transmit enable bit per channel, reset zero
// - partitions consecutive; h is 112..127
// - tx multichannel control layout, reset zero
// - rx multichannel control mirrors tx layout
// - element sizes 8..32, independent duplex framing
// - static logic, any low shift clock
// - double buffered data, gapless stream
`timescale 1ns/1ps
module bsp_top
   import bsp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        clkr_i,
   output logic             clkr_o,
   output logic             clkr_oe_n,
   input  wire logic        clkx_i,
   output logic             clkx_o,
   output logic             clkx_oe_n,
   input  wire logic        fsr_i,
   input  wire logic        fsx_i,
   input  wire logic        dr_i,
   input  wire logic        clks_i,
   output logic             dx_o,
   output logic             dx_oe_n,
   output logic             srcgen_clk
);
   import bsp_pkg::*;

   logic [15:0]  pc_q, rg2_q, mcr_rx_q, mcr_tx_q, cfg_q;
   logic [127:0] rce_q, xce_q;
   logic [31:0]  rdata_q, rx_hold_q, tx_sh_q, rx_sh_q;
   logic [2:0]   clkr_s_q, clkx_s_q, fsr_s_q, fsx_s_q, dr_s_q, clks_s_q;
   logic         clkr_f_q, clkx_f_q, fsr_f_q, fsx_f_q;
   logic         rx_full_q, rx_ovr_q;
   logic [5:0]   rbit_q, xbit_q;
   logic [6:0]   rch_q, xch_q;
   logic [6:0]   xch_nx;
   logic         tx_start, tx_nx_on;
   bsp_state_e   rst_q, xst_q;
   bsp_src_e     src;
   logic         rclk_edge, xclk_edge, rfs, xfs, rx_on, tx_on;
   logic         fifo_out_v, fifo_out_r, fifo_in_r, tx_load;
   logic [31:0]  fifo_out_d;
   logic [5:0]   elem_bits;
   bsp_req_s     req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign elem_bits = bsp_elem_bits(cfg_q[2:0]);

   // source selection from the two mode bits
   assign src = bsp_src_e'({pc_q[PC_SRC_EXT], rg2_q[RG2_CLK_MODE]});
   always_comb begin
      case (src)
         BSP_SRC_CPU:   srcgen_clk = 1'b1; // cpu clock: every cycle is a tick
         BSP_SRC_RXPIN: srcgen_clk = clkr_f_q;
         BSP_SRC_TXPIN: srcgen_clk = clkx_f_q;
         default:       srcgen_clk = 1'b0; // reserved combination stays idle
      endcase
   end

   // pin drivers: a pin feeding the generator never drives
   assign clkr_oe_n = !(pc_q[PC_CLKR_DIR] && src != BSP_SRC_RXPIN);
   assign clkx_oe_n = !(pc_q[PC_CLKX_DIR] && src != BSP_SRC_TXPIN);
   assign clkr_o = clkr_s_q[2] ^ pc_q[PC_CLKR_POL];
   assign clkx_o = (src == BSP_SRC_RXPIN) ? clkr_s_q[2] : clkx_s_q[2];

   // three-stage pin samplers; stage one feeds only stage two
   always_ff @(posedge clk) begin
      if (srst) begin
         clkr_s_q <= '0;
         clkx_s_q <= '0;
         fsr_s_q <= '0;
         fsx_s_q <= '0;
         dr_s_q <= '0;
         clks_s_q <= '0;
      end else begin
         clkr_s_q <= {clkr_s_q[1:0], clkr_i};
         clkx_s_q <= {clkx_s_q[1:0], clkx_i};
         fsr_s_q <= {fsr_s_q[1:0], fsr_i};
         fsx_s_q <= {fsx_s_q[1:0], fsx_i};
         dr_s_q <= {dr_s_q[1:0], dr_i};
         clks_s_q <= {clks_s_q[1:0], clks_i};
      end
   end

   // filtered levels, updated only once stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         clkr_f_q <= 1'b0;
         clkx_f_q <= 1'b0;
         fsr_f_q <= 1'b0;
         fsx_f_q <= 1'b0;
      end else begin
         if (clkr_s_q[1] == clkr_s_q[2]) clkr_f_q <= clkr_s_q[2];
         if (clkx_s_q[1] == clkx_s_q[2]) clkx_f_q <= clkx_s_q[2];
         if (fsr_s_q[1] == fsr_s_q[2]) fsr_f_q <= fsr_s_q[2];
         if (fsx_s_q[1] == fsx_s_q[2]) fsx_f_q <= fsx_s_q[2];
      end
   end

   // edge enables: no free-running clock assumed, so any slow rate works
   assign rclk_edge = (clkr_s_q[1] == clkr_s_q[2]) && (clkr_s_q[2] != clkr_f_q) &&
                      (clkr_s_q[2] ^ pc_q[PC_CLKR_POL]) == 1'b0;
   assign xclk_edge = (clkx_s_q[1] == clkx_s_q[2]) && (clkx_s_q[2] != clkx_f_q) &&
                      (clkx_s_q[2] ^ pc_q[PC_CLKX_POL]) == 1'b1;
   // sync level as it stands at the clock edge; the filtered copy lags by a cycle
   assign rfs = ((fsr_s_q[1] == fsr_s_q[2]) ? fsr_s_q[2] : fsr_f_q) ^ pc_q[PC_FSR_POL];
   assign xfs = ((fsx_s_q[1] == fsx_s_q[2]) ? fsx_s_q[2] : fsx_f_q) ^ pc_q[PC_FSX_POL];
   assign rx_on = bsp_chan_on(rce_q, rch_q, mcr_rx_q[MC_ENH]);
   assign tx_on = bsp_chan_on(xce_q, xch_q, mcr_tx_q[MC_ENH]);

   // register writes; read-only fields masked out
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_q <= RST_ZERO;
         rg2_q <= RST_ZERO;
         mcr_rx_q <= RST_ZERO;
         mcr_tx_q <= RST_ZERO;
         cfg_q <= RST_ZERO;
      end else if (req.wr) begin
         case (req.addr)
            OFF_PIN_CTRL:  pc_q <= req.wdata[15:0] & PC_RW_MASK;
            OFF_RATE_GEN2: rg2_q <= req.wdata[15:0] & RG2_RW_MASK;
            OFF_MCR_RX:    mcr_rx_q <= req.wdata[15:0] & MC_RW_MASK;
            OFF_MCR_TX:    mcr_tx_q <= req.wdata[15:0] & MC_RW_MASK;
            OFF_CFG:       cfg_q <= req.wdata[15:0];
            default:       ;
         endcase
      end
   end

   // channel enable tables, one word per 16-channel partition
   always_ff @(posedge clk) begin
      if (srst) begin
         rce_q <= '0;
         xce_q <= '0;
      end else if (req.wr) begin
         for (int p = 0; p < NUM_PART; p++) begin
            if (req.addr == OFF_RCE_BASE + 8'(4 * p))
               rce_q[p*PART_CH +: PART_CH] <= req.wdata[15:0];
            if (req.addr == OFF_XCE_BASE + 8'(4 * p))
               xce_q[p*PART_CH +: PART_CH] <= req.wdata[15:0];
         end
      end
   end

   // read mux, data one cycle later; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= '0;
      end else if (req.rd) begin
         rdata_q <= '0;
         case (req.addr)
            OFF_PIN_CTRL:  rdata_q[15:0] <= pc_q | {9'h0, clks_s_q[2], dx_o, dr_s_q[2], 4'h0};
            OFF_RATE_GEN2: rdata_q[15:0] <= rg2_q;
            OFF_MCR_RX:    rdata_q[15:0] <= mcr_rx_q | {11'h0, rch_q[6:4], 2'h0};
            OFF_MCR_TX:    rdata_q[15:0] <= mcr_tx_q | {11'h0, xch_q[6:4], 2'h0};
            OFF_CFG:       rdata_q[15:0] <= cfg_q;
            OFF_RX_DATA:   rdata_q <= rx_hold_q;
            OFF_STATUS:    rdata_q <= {29'h0, rx_ovr_q, fifo_in_r, rx_full_q};
            default: begin
               for (int p = 0; p < NUM_PART; p++) begin
                  if (req.addr == OFF_RCE_BASE + 8'(4 * p))
                     rdata_q[15:0] <= rce_q[p*PART_CH +: PART_CH];
                  if (req.addr == OFF_XCE_BASE + 8'(4 * p))
                     rdata_q[15:0] <= xce_q[p*PART_CH +: PART_CH];
               end
            end
         endcase
      end
   end
   assign reg_rdata = rdata_q;

   // transmit fifo: second buffer behind the shifter for gapless words
   bsp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_data   (req.wdata),
      .in_valid  (req.wr && req.addr == OFF_TX_DATA),
      .in_ready  (fifo_in_r),
      .out_data  (fifo_out_d),
      .out_valid (fifo_out_v),
      .out_ready (fifo_out_r)
   );
   // next channel index; a frame sync or the last slot wraps to zero
   assign xch_nx = (xfs || xch_q == 7'(cfg_q[14:8])) ? 7'h00 : xch_q + 7'h01;
   // a channel starts on sync from idle, or right after the last bit of the one before
   assign tx_start = xclk_edge && ((xst_q == BSP_IDLE && xfs) ||
                                   (xst_q == BSP_DONE && (xfs || xch_q != 7'(cfg_q[14:8]))));
   // only enabled slots take a word, so disabled slots never eat queued data
   assign tx_nx_on = bsp_chan_on(xce_q, xch_nx, mcr_tx_q[MC_ENH]);
   assign tx_load = tx_start && tx_nx_on;
   assign fifo_out_r = tx_load;

   // transmitter: element per channel, frame sync restarts channel count
   always_ff @(posedge clk) begin
      if (srst) begin
         xst_q <= BSP_IDLE;
         xbit_q <= '0;
         xch_q <= '0;
         tx_sh_q <= '0;
      end else if (xclk_edge) begin
         case (xst_q)
            BSP_IDLE: begin
               if (tx_start) begin
                  xst_q <= BSP_SHIFT;
                  xch_q <= xch_nx;
                  xbit_q <= elem_bits - 6'h02;
                  tx_sh_q <= (tx_load && fifo_out_v) ? fifo_out_d : '0;
               end
            end
            BSP_SHIFT: begin
               tx_sh_q <= {tx_sh_q[30:0], 1'b0};
               if (xbit_q == 6'h00) begin
                  xst_q <= BSP_DONE;
               end else begin
                  xbit_q <= xbit_q - 6'h01;
               end
            end
            BSP_DONE: begin
               // last bit stands here; next channel follows with no gap unless frame ends
               xst_q <= tx_start ? BSP_SHIFT : BSP_IDLE;
               xch_q <= xch_nx;
               xbit_q <= elem_bits - 6'h02;
               tx_sh_q <= (tx_load && fifo_out_v) ? fifo_out_d : '0;
            end
            default: xst_q <= BSP_IDLE;
         endcase
      end
   end
   // line driven for every bit of an enabled slot, last bit included
   assign dx_o = tx_sh_q[31];
   assign dx_oe_n = !((xst_q == BSP_SHIFT || xst_q == BSP_DONE) && tx_on);

   // receiver, independent clock and sync from the transmitter
   always_ff @(posedge clk) begin
      if (srst) begin
         rst_q <= BSP_IDLE;
         rbit_q <= '0;
         rch_q <= '0;
         rx_sh_q <= '0;
      end else if (rclk_edge) begin
         case (rst_q)
            BSP_IDLE: begin
               if (rfs) begin
                  rst_q <= BSP_SHIFT;
                  rch_q <= '0;
                  rbit_q <= elem_bits - 6'h02;
                  rx_sh_q <= {rx_sh_q[30:0], dr_s_q[2]}; // first bit shares the sync edge
               end
            end
            BSP_SHIFT: begin
               rx_sh_q <= {rx_sh_q[30:0], dr_s_q[2]};
               if (rbit_q == 6'h00) begin
                  rst_q <= BSP_DONE;
               end else begin
                  rbit_q <= rbit_q - 6'h01;
               end
            end
            BSP_DONE: begin
               rst_q <= (rfs || rch_q != 7'(cfg_q[14:8])) ? BSP_SHIFT : BSP_IDLE;
               rch_q <= (rfs || rch_q == 7'(cfg_q[14:8])) ? 7'h00 : rch_q + 7'h01;
               rbit_q <= elem_bits - 6'h02;
               rx_sh_q <= {rx_sh_q[30:0], dr_s_q[2]}; // no gap: next word's first bit
            end
            default: rst_q <= BSP_IDLE;
         endcase
      end
   end

   // receive holding register: only enabled channels land; new word beats clear
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_hold_q <= '0;
         rx_full_q <= 1'b0;
         rx_ovr_q <= 1'b0;
      end else begin
         if (rclk_edge && rst_q == BSP_DONE && rx_on) begin
            rx_hold_q <= rx_sh_q;
            rx_full_q <= 1'b1;
            if (rx_full_q) rx_ovr_q <= 1'b1;
         end else if (req.rd && req.addr == OFF_RX_DATA) begin
            rx_full_q <= 1'b0;
         end
      end
   end
endmodule // bsp_top

// >>> inc/bsp_pkg.sv
// package for the buffered serial port clock source and channel selection block
package bsp_pkg;
   // register byte address map (word index = byte address / 4)
   localparam logic [7:0] OFF_PIN_CTRL = 8'h00;
   localparam logic [7:0] OFF_RATE_GEN2 = 8'h04;
   localparam logic [7:0] OFF_MCR_RX = 8'h08;
   localparam logic [7:0] OFF_MCR_TX = 8'h0c;
   localparam logic [7:0] OFF_RCE_BASE = 8'h40; // 8 words, partitions a..h
   localparam logic [7:0] OFF_XCE_BASE = 8'h60; // 8 words, partitions a..h
   localparam logic [7:0] OFF_CFG = 8'h10;      // element size and frame length
   localparam logic [7:0] OFF_RX_DATA = 8'h14;
   localparam logic [7:0] OFF_TX_DATA = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   // pin control fields
   localparam int PC_CLKR_POL = 0;
   localparam int PC_CLKX_POL = 1;
   localparam int PC_FSR_POL = 2;
   localparam int PC_FSX_POL = 3;
   localparam int PC_RX_DATA_PIN_STATUS = 4;
   localparam int PC_TX_DATA_PIN_STATUS = 5;
   localparam int PC_EXT_CLOCK_PIN_STATUS = 6;
   localparam int PC_SRC_EXT = 7;
   localparam int PC_CLKR_DIR = 8;
   localparam int PC_CLKX_DIR = 9;
   localparam int PC_FSR_DIR = 10;
   localparam int PC_FSX_DIR = 11;
   localparam int PC_RX_GPIO = 12;
   localparam int PC_TX_GPIO = 13;
   localparam logic [15:0] PC_RW_MASK = 16'h3f8f;
   localparam int RG2_CLK_MODE = 13;
   localparam logic [15:0] RG2_RW_MASK = 16'h2000;
   // multichannel control fields
   localparam int MC_ENH = 9;
   localparam int MC_CBLK_LSB = 2;
   localparam logic [15:0] MC_RW_MASK = 16'h03e3;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam int NUM_PART = 8;
   localparam int PART_CH = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int DATA_W = 32;

   typedef enum logic [1:0] {
      BSP_SRC_RSVD = 2'b00,
      BSP_SRC_CPU = 2'b01,
      BSP_SRC_RXPIN = 2'b10,
      BSP_SRC_TXPIN = 2'b11
   } bsp_src_e;

   typedef enum logic [1:0] {
      BSP_IDLE = 2'b00,
      BSP_SHIFT = 2'b01,
      BSP_DONE = 2'b11
   } bsp_state_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bsp_req_s;

   // element size code to bit count: 8,12,16,20,24,32
   function automatic logic [5:0] bsp_elem_bits(input logic [2:0] code);
      case (code)
         3'h0: bsp_elem_bits = 6'h08;
         3'h1: bsp_elem_bits = 6'h0c;
         3'h2: bsp_elem_bits = 6'h10;
         3'h3: bsp_elem_bits = 6'h14;
         3'h4: bsp_elem_bits = 6'h18;
         default: bsp_elem_bits = 6'h20;
      endcase
   endfunction

   // channel enable lookup in 16-channel partitions
   function automatic logic bsp_chan_on(input logic [127:0] ena, input logic [6:0] ch,
                                        input logic enh);
      if (!enh && ch[6:5] != 2'b00) bsp_chan_on = 1'b0;
      else bsp_chan_on = ena[ch];
   endfunction
endpackage

// >>> hdl/bsp_fifo.sv
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ps
module bsp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest flags from the occupancy count
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk) begin
      if (srst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + AW'(1);
         if (pop) rp_q <= rp_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // bsp_fifo

// >>> testbench/bsp_top_chk.sv
// concurrent checks on clock source, pin drive and register reads
`timescale 1ns/1ps
module bsp_top_chk
   import bsp_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        clkr_i,
   input wire logic        clkr_o,
   input wire logic        clkr_oe_n,
   input wire logic        clkx_i,
   input wire logic        clkx_o,
   input wire logic        clkx_oe_n,
   input wire logic        fsr_i,
   input wire logic        fsx_i,
   input wire logic        dr_i,
   input wire logic        clks_i,
   input wire logic        dx_o,
   input wire logic        dx_oe_n,
   input wire logic        srcgen_clk
);
   logic [15:0]      pc_q;
   logic [15:0]      rg_q;
   logic [7:0][15:0] xce_q;
   logic [1:0]       calm_q;
   logic [1:0]       sel;
   logic             calm;

   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);

   // source code as the two control bits combine
   assign sel = {pc_q[PC_SRC_EXT], rg_q[RG2_CLK_MODE]};
   assign calm = (calm_q == 2'h3);

   // shadow of pin control and clock mode, writable bits only
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_q <= RST_ZERO;
         rg_q <= RST_ZERO;
      end else if (reg_wr && reg_addr == OFF_PIN_CTRL) begin
         pc_q <= reg_wdata[15:0] & PC_RW_MASK;
      end else if (reg_wr && reg_addr == OFF_RATE_GEN2) begin
         rg_q <= reg_wdata[15:0] & RG2_RW_MASK;
      end
   end

   // shadow of the transmit enables
   always_ff @(posedge clk) begin
      if (srst) begin
         xce_q <= '0;
      end else if (reg_wr && reg_addr[7:5] == 3'h3) begin
         xce_q[reg_addr[4:2]] <= reg_wdata[15:0];
      end
   end

   // cycles since the last write; pin outputs may lag a write slightly
   always_ff @(posedge clk) begin
      if (srst || reg_wr) begin
         calm_q <= 2'h0;
      end else if (!calm) begin
         calm_q <= calm_q + 2'h1;
      end
   end

   chk_src_cpu_high: assert property (calm && sel == BSP_SRC_CPU |-> srcgen_clk)
      else $error("generator input low with cpu source");
   chk_src_rx_pin: assert property ($stable(clkr_i)[*6] ##0 (calm && sel == BSP_SRC_RXPIN
      && pc_q[1:0] == 2'h0) |-> srcgen_clk == clkr_i)
      else $error("generator input does not follow rx clock pin");
   chk_rx_pin_drive: assert property (calm |-> clkr_oe_n ==
      (!pc_q[PC_CLKR_DIR] || sel == BSP_SRC_RXPIN))
      else $error("rx clock pin drive wrong");
   chk_tx_pin_drive: assert property (calm |-> clkx_oe_n ==
      (!pc_q[PC_CLKX_DIR] || sel == BSP_SRC_TXPIN))
      else $error("tx clock pin drive wrong");
   chk_pin_ctrl_read: assert property (reg_rd && reg_addr == OFF_PIN_CTRL |=>
      (reg_rdata & 32'hffff_ff8f) == {16'h0000, $past(pc_q)})
      else $error("pin control read back wrong");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_dx_quiet: assert property (calm && xce_q == '0 |-> dx_oe_n)
      else $error("data driven with no transmit slot enabled");
endmodule // bsp_top_chk

bind bsp_top bsp_top_chk i_bsp_top_chk (
   .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clkr_i(clkr_i),
   .clkr_o(clkr_o), .clkr_oe_n(clkr_oe_n), .clkx_i(clkx_i), .clkx_o(clkx_o),
   .clkx_oe_n(clkx_oe_n), .fsr_i(fsr_i), .fsx_i(fsx_i), .dr_i(dr_i), .clks_i(clks_i),
   .dx_o(dx_o), .dx_oe_n(dx_oe_n), .srcgen_clk(srcgen_clk)
);

// >>> testbench/bsp_codec_model.sv
// far-side codec: slow bit clock, frame syncs and slot data
`timescale 1ns/1ps
module bsp_codec_model (
   output logic      bclk,
   output logic      fs_rx,
   output logic      fs_tx,
   output logic      dr,
   input  wire logic dx,
   input  wire logic dx_oe_n
);
   int          drv_bits;
   logic [31:0] drv_word;

   // idle: clock parked low, syncs low
   initial begin
      bclk = 1'b0;
      fs_rx = 1'b0;
      fs_tx = 1'b0;
      dr = 1'b1;
      drv_bits = 0;
   end

   // one frame of 8-bit slots plus two trailing slots; the clock only runs for these
   task automatic frame(input int nch, input int hot);
      logic [7:0] w;
      drv_bits = 0;
      drv_word = '0;
      #7;
      for (int b = 0; b < nch * 8 + 16; b++) begin
         w = (b / 8 == hot) ? 8'ha5 : 8'h3c;
         // line settled since the last rise: count the driven bit and keep it
         if (dx_oe_n === 1'b0) begin
            drv_bits++;
            drv_word = {drv_word[30:0], dx};
         end
         bclk = 1'b1;
         fs_rx = (b == 0);
         fs_tx = (b == 0);
         dr = w[7 - b % 8];
         #80 bclk = 1'b0;
         #80;
      end
      dr = ~dr; // released line must not look held
   endtask
endmodule // bsp_codec_model

// >>> testbench/tb.sv
// self-checking bench for clock source and channel selection
`timescale 1ns/1ps
module tb;
   import bsp_pkg::*;
   logic        clk, srst, reg_wr, reg_rd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        clkr_o, clkr_oe_n, clkx_o, clkx_oe_n;
   logic        dx_o, dx_oe_n, srcgen_clk, bclk, fsr, fsx, dr;
   wire         clkr_w, clkx_w;
   int          n_mismatch, n_compared;

   // pin level: design drives while its enable is low, else the codec
   assign clkr_w = clkr_oe_n ? bclk : clkr_o;
   assign clkx_w = clkx_oe_n ? bclk : clkx_o;

   bsp_top i_bsp_top (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .clkr_i(clkr_w), .clkr_o(clkr_o), .clkr_oe_n(clkr_oe_n),
      .clkx_i(clkx_w), .clkx_o(clkx_o), .clkx_oe_n(clkx_oe_n),
      .fsr_i(fsr), .fsx_i(fsx), .dr_i(dr), .clks_i(1'b0),
      .dx_o(dx_o), .dx_oe_n(dx_oe_n), .srcgen_clk(srcgen_clk)
   );

   bsp_codec_model i_bsp_codec_model (
      .bclk(bclk), .fs_rx(fsr), .fs_tx(fsx), .dr(dr), .dx(dx_o), .dx_oe_n(dx_oe_n)
   );

   always #10 clk = ~clk;

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      logic [31:0] v;
      clk = 1'b0;
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      // every control register but the configuration word clear after reset, status bits masked
      rd(OFF_PIN_CTRL, v);
      chk(v & 32'hffff_ff8f, 32'h0);
      rd(OFF_RATE_GEN2, v);
      chk(v, 32'h0);
      rd(OFF_MCR_RX, v);
      chk(v, 32'h0);
      rd(OFF_MCR_TX, v);
      chk(v, 32'h0);
      for (int p = 0; p < NUM_PART; p++) begin
         rd(OFF_RCE_BASE + 8'(4 * p), v);
         chk(v, 32'h0);
         rd(OFF_XCE_BASE + 8'(4 * p), v);
         chk(v, 32'h0);
      end
      $display("reset values done");
      // all ones written: only writable bits come back
      wr(OFF_PIN_CTRL, 32'hffff_ffff);
      rd(OFF_PIN_CTRL, v);
      chk(v & 32'hffff_ff8f, 32'h3f8f);
      // park the pins first: an inverted pin clock driven back into itself would run
      wr(OFF_PIN_CTRL, 32'h0);
      wr(OFF_RATE_GEN2, 32'hffff_ffff);
      rd(OFF_RATE_GEN2, v);
      chk(v, 32'h2000);
      for (int m = 0; m < 2; m++) begin
         wr(m ? OFF_MCR_TX : OFF_MCR_RX, 32'hffff_ffff);
         rd(m ? OFF_MCR_TX : OFF_MCR_RX, v);
         chk(v & 32'hffff_ffe3, 32'h03e3);
         wr(m ? OFF_MCR_TX : OFF_MCR_RX, 32'h0);
      end
      for (int p = 0; p < NUM_PART; p++) begin
         wr(OFF_RCE_BASE + 8'(4 * p), 32'hffff_0000 | (32'h8001 >> p));
         wr(OFF_XCE_BASE + 8'(4 * p), 32'h7ffe << p);
      end
      for (int p = 0; p < NUM_PART; p++) begin
         rd(OFF_RCE_BASE + 8'(4 * p), v);
         chk(v, 32'h8001 >> p);
         rd(OFF_XCE_BASE + 8'(4 * p), v);
         chk(v, (32'h7ffe << p) & 32'hffff);
         wr(OFF_RCE_BASE + 8'(4 * p), 32'h0);
         wr(OFF_XCE_BASE + 8'(4 * p), 32'h0);
      end
      wr(8'h24, 32'hffff_ffff);
      rd(8'h20, v);
      chk(v, 32'h0);
      $display("register access done");
      // each source code with both clock pins set to drive
      for (int c = 0; c < 4; c++) begin
         wr(OFF_PIN_CTRL, 32'h0300 | (32'(c / 2) << 7));
         wr(OFF_RATE_GEN2, 32'(c % 2) << 13);
         repeat (4) @(posedge clk);
         #1 chk({29'h0, clkr_oe_n, clkx_oe_n, srcgen_clk}, {29'h0, c == 2, c == 3, c == 1});
      end
      $display("clock source done");
      // overfill the transmit buffer with no link clock running
      wr(OFF_PIN_CTRL, 32'h0);
      for (int i = 0; i < 20; i++) wr(OFF_TX_DATA, 32'h5a00_0000 + (32'(i) << 24));
      rd(OFF_STATUS, v);
      chk(v & 32'h2, 32'h0);
      // 34 byte slots: tx slots 1 and 32, rx slot 2 only
      wr(OFF_CFG, 32'h2100);
      wr(OFF_XCE_BASE, 32'h2);
      wr(OFF_XCE_BASE + 8'h08, 32'h1);
      wr(OFF_RCE_BASE, 32'h4);
      i_bsp_codec_model.frame(34, 2);
      chk(32'(i_bsp_codec_model.drv_bits), 32'h8);
      chk(i_bsp_codec_model.drv_word, 32'h5a);
      rd(OFF_STATUS, v);
      chk(v & 32'h1, 32'h1);
      rd(OFF_RX_DATA, v);
      chk(v & 32'hff, 32'ha5);
      $display("narrow mode frame done");
      wr(OFF_MCR_TX, 32'h200);
      wr(OFF_MCR_RX, 32'h200);
      i_bsp_codec_model.frame(34, 2);
      chk(32'(i_bsp_codec_model.drv_bits), 32'h10);
      chk(i_bsp_codec_model.drv_word, 32'h5b5c);
      rd(OFF_STATUS, v);
      chk(v & 32'h7, 32'h3);
      $display("wide mode frame done");
      close_out();
   end
endmodule // tb
